// [logic/acsr_pkg.sv]
// constants and types for the converter control and serial readout block
package acsr_pkg;

  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned CONV_TIME_NS  = 650;
  localparam int unsigned CONV_CYCLES   =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PWRUP_TIME_US = 100;
  localparam int unsigned PWRUP_CYCLES  =
    (PWRUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned RESULT_BITS   = 12;
  localparam int unsigned CONV_CNT_W    = 8;
  localparam int unsigned FALL_CNT_W    = 4;
  localparam logic [FALL_CNT_W-1:0] FALLS_BUSY  = 4'hD;
  localparam logic [FALL_CNT_W-1:0] FALLS_PLAIN = 4'hC;
  localparam logic [FALL_CNT_W-1:0] SWR_MIN_FALL = 4'h2;
  localparam logic [FALL_CNT_W-1:0] SWR_MAX_FALL = 4'h8;
  localparam logic [CONV_CNT_W-1:0] CONV_LOAD =
    CONV_CNT_W'(CONV_CYCLES);

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic conv_start_n;
  } acsr_pins_t;

  localparam acsr_pins_t PINS_IDLE = '{sclk: 1'b0, cs_n: 1'b1,
                                       conv_start_n: 1'b1};

  typedef enum logic [1:0] {
    RD_IDLE     = 2'h0,
    RD_BUSY_LOW = 2'h1,
    RD_SHIFT    = 2'h3,
    RD_DONE     = 2'h2
  } acsr_rd_state_t;

endpackage : acsr_pkg

// [logic/acsr_top.sv]
// converter control, power mode and serial result readout
// Notes on behaviour
// - interface is serial clock, three-state data, conversion start, chip select
// - chip select fall drives data out when no conversion is running; chip select rise floats it
// - chip select low at end of conversion selects busy-indicator mode
// - conversion start fall begins conversion and holds the input sample
// - conversion lasts 650 ns; track resumes at completion
// - busy mode drives data low at end of conversion
// - busy mode: first clock fall shows msb, eleven bits follow msb first
// - busy-mode read is 13 clocks, 13th fall floats data
// - busy mode releases data on 13th clock fall
// - bits change on clock falls; host samples on next clock edge
// - plain mode: msb shown at chip select fall, rest on clock falls
// - plain mode releases data on 12th clock fall
// - chip select rise after falls two to eight requests software reset
// - requested software reset executes at the next end of conversion
// - conversion start low at completion enters power-down; readout works
// - conversion start rise begins 100 us power-up
`timescale 1ns/1ns
`default_nettype none
module acsr_top
  import acsr_pkg::*;
#(
  parameter int unsigned PWRUP_CNT = acsr_pkg::PWRUP_CYCLES
)
(
  input  wire  logic                   clk_in,
  input  wire  logic                   rst_in,
  input  wire  logic                   ce_in,
  input  wire  acsr_pkg::acsr_pins_t   pins_in,
  input  wire  logic [11:0]            sample_in,
  output logic                         serial_result_out,
  output logic                         serial_result_oe_n_out,
  output logic                         track_out,
  output logic                         power_down_out,
  output logic                         soft_reset_out
);
  import acsr_pkg::*;

  localparam int unsigned PU_W = $clog2(PWRUP_CNT + 1);
  localparam logic [PU_W-1:0] PU_LOAD = PU_W'(PWRUP_CNT);

  acsr_pins_t                  pin_meta;
  acsr_pins_t                  pin_sync;
  acsr_pins_t                  pin_prev;
  logic [CONV_CNT_W-1:0]       conv_cnt;
  logic [PU_W-1:0]             pu_cnt;
  logic [RESULT_BITS-1:0]      held;
  logic [RESULT_BITS-1:0]      shift_reg;
  logic [FALL_CNT_W-1:0]       fall_cnt;
  logic [FALL_CNT_W-1:0]       fall_limit;
  logic                        swr_pending;
  acsr_rd_state_t              rd_state;

  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic conv_fall;
  logic conv_rise;
  logic eoc;
  logic swr_hit;

  // pins come from the host's domain: two flops before any use
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pin_meta <= PINS_IDLE;
      pin_sync <= PINS_IDLE;
      pin_prev <= PINS_IDLE;
    end
    else if (ce_in)
    begin
      pin_meta <= pins_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign sclk_fall = pin_prev.sclk & ~pin_sync.sclk;
  assign cs_fall   = pin_prev.cs_n & ~pin_sync.cs_n;
  assign cs_rise   = ~pin_prev.cs_n & pin_sync.cs_n;
  assign conv_fall = pin_prev.conv_start_n & ~pin_sync.conv_start_n;
  assign conv_rise = ~pin_prev.conv_start_n & pin_sync.conv_start_n;
  assign eoc       = (conv_cnt == CONV_CNT_W'(1));
  // short-cycled read: chip select rises after falls two to eight
  assign swr_hit   = cs_rise && (rd_state == RD_SHIFT) &&
                     (fall_cnt >= SWR_MIN_FALL) &&
                     (fall_cnt <= SWR_MAX_FALL);

  // conversion timing and track-and-hold
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      conv_cnt  <= '0;
      track_out <= 1'b1;
      held      <= '0;
    end
    else if (ce_in)
    begin
      if (conv_cnt != '0)
      begin
        conv_cnt <= conv_cnt - CONV_CNT_W'(1);
        if (eoc)
          track_out <= 1'b1;
      end
      else if (conv_fall && !power_down_out)
      begin
        conv_cnt  <= CONV_LOAD;
        track_out <= 1'b0;
        held      <= sample_in;
      end
    end
  end

  // power mode: low start level at completion powers down
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      power_down_out <= 1'b0;
      pu_cnt         <= '0;
    end
    else if (ce_in)
    begin
      if (eoc && !pin_sync.conv_start_n)
      begin
        power_down_out <= 1'b1;
        pu_cnt         <= '0;
      end
      else if (pu_cnt != '0)
      begin
        pu_cnt <= pu_cnt - PU_W'(1);
        if (pu_cnt == PU_W'(1))
          power_down_out <= 1'b0;
      end
      else if (power_down_out && conv_rise)
        pu_cnt <= PU_LOAD;
    end
  end

  // software reset request, executed at the next completion
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      swr_pending    <= 1'b0;
      soft_reset_out <= 1'b0;
    end
    else if (ce_in)
    begin
      soft_reset_out <= eoc && swr_pending;
      if (swr_hit)
        swr_pending <= 1'b1;
      else if (eoc)
        swr_pending <= 1'b0;
    end
  end

  // serial readout; the data pin drives only between framing edges
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rd_state               <= RD_IDLE;
      shift_reg              <= '0;
      fall_cnt               <= '0;
      fall_limit             <= FALLS_PLAIN;
      serial_result_out      <= 1'b0;
      serial_result_oe_n_out <= 1'b1;
    end
    else if (ce_in)
    begin
      if (eoc)
      begin
        shift_reg <= held;
        fall_cnt  <= '0;
        if (!pin_sync.cs_n)
        begin
          rd_state               <= RD_BUSY_LOW;
          fall_limit             <= FALLS_BUSY;
          serial_result_out      <= 1'b0;
          serial_result_oe_n_out <= 1'b0;
        end
        else
        begin
          rd_state               <= RD_IDLE;
          fall_limit             <= FALLS_PLAIN;
          serial_result_oe_n_out <= 1'b1;
        end
      end
      else if (cs_rise)
      begin
        rd_state               <= RD_IDLE;
        serial_result_oe_n_out <= 1'b1;
      end
      else
      begin
        case (rd_state)
          RD_IDLE:
          begin
            // a frame opened mid-conversion would corrupt the busy line
            if (cs_fall && conv_cnt == '0)
            begin
              rd_state               <= RD_SHIFT;
              fall_cnt               <= '0;
              fall_limit             <= FALLS_PLAIN;
              serial_result_out      <= shift_reg[RESULT_BITS-1];
              shift_reg              <= shift_reg << 1;
              serial_result_oe_n_out <= 1'b0;
            end
          end
          RD_BUSY_LOW:
          begin
            if (sclk_fall)
            begin
              rd_state          <= RD_SHIFT;
              fall_cnt          <= FALL_CNT_W'(1);
              serial_result_out <= shift_reg[RESULT_BITS-1];
              shift_reg         <= shift_reg << 1;
            end
          end
          RD_SHIFT:
          begin
            if (sclk_fall)
            begin
              fall_cnt <= fall_cnt + FALL_CNT_W'(1);
              if (fall_cnt + FALL_CNT_W'(1) == fall_limit)
              begin
                rd_state               <= RD_DONE;
                serial_result_oe_n_out <= 1'b1;
              end
              else
              begin
                serial_result_out <= shift_reg[RESULT_BITS-1];
                shift_reg         <= shift_reg << 1;
              end
            end
          end
          RD_DONE:
          begin
            rd_state <= RD_DONE;
          end
          default:
          begin
            rd_state               <= RD_IDLE;
            serial_result_oe_n_out <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule : acsr_top
`default_nettype wire

// [sim/acsr_props.sv]
// assertions on the converter control block ports
`timescale 1ns/1ns
`default_nettype none
module acsr_props
  import acsr_pkg::*;
#(parameter int unsigned PWRUP_CNT = 50)
(
  input wire logic                 clk_in,
  input wire logic                 rst_in,
  input wire logic                 ce_in,
  input wire acsr_pkg::acsr_pins_t pins_in,
  input wire logic [11:0]          sample_in,
  input wire logic                 serial_result_out,
  input wire logic                 serial_result_oe_n_out,
  input wire logic                 track_out,
  input wire logic                 power_down_out,
  input wire logic                 soft_reset_out
);
  logic [8:0]  lo_cnt;
  logic [15:0] hi_cnt;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // counters pause with the clock enable, as the design does
  always_ff @(posedge clk_in)
    lo_cnt <= (rst_in || track_out) ? 9'h000 :
              ce_in ? lo_cnt + 9'h001 : lo_cnt;
  always_ff @(posedge clk_in)
    hi_cnt <= (rst_in || !power_down_out || !pins_in.conv_start_n) ?
              16'h0000 : ce_in ? hi_cnt + 16'h0001 : hi_cnt;
  conv_time_a: assert property ($rose(track_out) |-> lo_cnt == CONV_CYCLES)
    else $error("conversion length wrong");
  conv_cause_a: assert property ($fell(track_out) |->
    !pins_in.conv_start_n && !power_down_out)
    else $error("hold without start");
  cs_release_a: assert property ($rose(pins_in.cs_n) |->
    ##[1:6] serial_result_oe_n_out)
    else $error("data not released");
  busy_low_a: assert property ($rose(track_out) &&
    !serial_result_oe_n_out |-> !serial_result_out)
    else $error("busy level not low");
  pd_entry_a: assert property ($rose(power_down_out) |-> $rose(track_out))
    else $error("power-down off eoc");
  pwrup_time_a: assert property ($fell(power_down_out) |->
    hi_cnt inside {[PWRUP_CNT:PWRUP_CNT+8]})
    else $error("power-up time wrong");
  swr_pulse_a: assert property (soft_reset_out |->
    $rose(track_out) ##1 !soft_reset_out)
    else $error("reset pulse wrong");
  stay_off_a: assert property ($rose(serial_result_oe_n_out) &&
    !pins_in.cs_n |=> serial_result_oe_n_out [*8])
    else $error("data driven after release");
endmodule : acsr_props
bind acsr_top acsr_props #(.PWRUP_CNT(PWRUP_CNT)) acsr_props_i (
  .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .pins_in(pins_in),
  .sample_in(sample_in), .serial_result_out(serial_result_out),
  .serial_result_oe_n_out(serial_result_oe_n_out), .track_out(track_out),
  .power_down_out(power_down_out), .soft_reset_out(soft_reset_out));
`default_nettype wire

// [sim/acsr_host.sv]
// host serial controller model driving the converter pins
`timescale 1ns/1ns
`default_nettype none
module acsr_host
(
  input  wire logic                clk_in,
  input  wire logic                sdo_in,
  output var acsr_pkg::acsr_pins_t pins_out
);
  import acsr_pkg::*;
  initial pins_out = PINS_IDLE;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  // keep_pd leaves start low through completion
  // leading wait settles the input mux and keeps the quiet interval
  task automatic conv(input logic keep_pd);
    tick(90);
    pins_out.conv_start_n <= 1'b0;
    tick(8);
    pins_out.conv_start_n <= !keep_pd;
    tick(190);
  endtask : conv
  task automatic up(input int n);
    pins_out.conv_start_n <= 1'b1;
    tick(n);
  endtask : up
  task automatic cs(input logic v);
    pins_out.cs_n <= v;
    tick(16);
  endtask : cs
  // sample in the high phase; one more sample after the last fall
  task automatic read(input int n, output logic [31:0] q);
    q = '0;
    repeat (n)
    begin
      pins_out.sclk <= 1'b1;
      tick(16);
      q = {q[30:0], sdo_in};
      pins_out.sclk <= 1'b0;
      tick(16);
    end
    q = {q[30:0], sdo_in};
  endtask : read
endmodule : acsr_host
`default_nettype wire

// [sim/acsr_top_tb.sv]
// self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module acsr_top_tb;
  import acsr_pkg::*;
  localparam int PWR = 50;
  logic        clk_in    = 1'b0;
  logic        rst_in    = 1'b1;
  logic [11:0] sample_in = 12'h000;
  logic        ce        = 1'b1;
  int          lo_seen   = 0;
  acsr_pins_t  pins;
  logic        dat, oe_n, trk, pd, swr;
  int          err_total = 0, num_checks = 0, cyc = 0, swr_cnt = 0;
  // released line reads high through the pull-up
  wire         sdo_w = oe_n ? 1'b1 : dat;
  acsr_top #(.PWRUP_CNT(PWR)) acsr_top_i (.clk_in(clk_in), .rst_in(rst_in),
    .ce_in(ce), .pins_in(pins), .sample_in(sample_in),
    .serial_result_out(dat), .serial_result_oe_n_out(oe_n),
    .track_out(trk), .power_down_out(pd), .soft_reset_out(swr));
  acsr_host acsr_host_i (.clk_in(clk_in), .sdo_in(sdo_w), .pins_out(pins));
  always #2 clk_in = ~clk_in;
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (swr === 1'b1)
      swr_cnt <= swr_cnt + 1;
    if (trk === 1'b0)
      lo_seen <= lo_seen + 1;
    if (cyc == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic t_swr();
    logic [31:0] q;
    int          base;
    int          falls[4] = '{1, 2, 8, 9};
    foreach (falls[i])
    begin
      acsr_host_i.conv(1'b0);
      acsr_host_i.cs(1'b0);
      acsr_host_i.read(falls[i], q);
      acsr_host_i.cs(1'b1);
      base = swr_cnt;
      acsr_host_i.conv(1'b0);
      chk(32'(swr_cnt - base), 32'(falls[i] inside {[2:8]}));
    end
  endtask : t_swr
  task automatic t_busy();
    logic [31:0] q;
    sample_in <= 12'hA5C;
    acsr_host_i.cs(1'b0);
    acsr_host_i.conv(1'b0);
    acsr_host_i.read(16, q);
    acsr_host_i.cs(1'b1);
    chk(q, {16'h0000, 12'hA5C, 4'hF});
  endtask : t_busy
  task automatic t_plain();
    logic [31:0] q;
    sample_in <= 12'h3A6;
    acsr_host_i.conv(1'b0);
    acsr_host_i.cs(1'b0);
    acsr_host_i.read(12, q);
    acsr_host_i.cs(1'b1);
    chk(q, {19'h00000, 12'h3A6, 1'b1});
  endtask : t_plain
  task automatic t_pd();
    logic [31:0] q;
    sample_in <= 12'h5E1;
    acsr_host_i.conv(1'b1);
    chk({31'h0, pd}, 32'h1);
    acsr_host_i.cs(1'b0);
    acsr_host_i.read(12, q);
    acsr_host_i.cs(1'b1);
    chk(q, {19'h00000, 12'h5E1, 1'b1});
    acsr_host_i.up(PWR + 20);
    chk({31'h0, pd}, 32'h0);
  endtask : t_pd
  // a freeze in mid-conversion stretches the hold by the frozen cycles
  task automatic t_freeze();
    int base;
    base = lo_seen;
    fork
      acsr_host_i.conv(1'b0);
      begin
        repeat (150) @(posedge clk_in);
        ce <= 1'b0;
        repeat (40) @(posedge clk_in);
        ce <= 1'b1;
      end
    join
    repeat (40) @(posedge clk_in);
    chk(32'(lo_seen - base), 32'(CONV_CYCLES + 40));
  endtask : t_freeze
  initial
  begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    t_swr();
    t_busy();
    t_plain();
    t_pd();
    t_freeze();
    end_of_test();
  end
endmodule : acsr_top_tb
`default_nettype wire
